// [design/maint_pkg.sv]
// maintenance channel package: register indices, field positions, resets, timing
// assumes a 100 MHz single clock and a superframe framer on the same clock
package maint_pkg;

  // ****************************************
  // register indices
  // ****************************************
  localparam logic [3:0] ACT_STATUS_IDX  = 4'h0;
  localparam logic [3:0] ACT_CONTROL_IDX = 4'h1;
  localparam logic [3:0] IRQ_MASK_IDX    = 4'h2;
  localparam logic [3:0] M4_TX_IDX       = 4'h3;
  localparam logic [3:0] M4_RX_IDX       = 4'h4;
  localparam logic [3:0] M56_IDX         = 4'h5;
  localparam logic [3:0] VERIFIED_IDX    = 4'h6;
  localparam logic [3:0] MAINT_CTRL_IDX  = 4'h7;
  localparam logic [3:0] OVERLAY_IDX     = 4'h8;
  localparam logic [3:0] EOC_IDX         = 4'h9;
  localparam logic [3:0] IRQ_STATUS_IDX  = 4'hA;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CUST_EN_BIT  = 0;
  localparam int UPD_DIS_BIT  = 1;
  localparam int DEACT_BIT    = 2;
  localparam int ACT_BIT      = 7;
  localparam int DEA_BIT      = 6;
  localparam int FEBE_BIT     = 4;
  localparam int FEBE_CTL_BIT = 1;
  localparam int IRQ_M56      = 0;
  localparam int IRQ_M4       = 1;
  localparam int IRQ_EOC      = 2;
  localparam int IRQ_STAT     = 3;
  localparam logic [7:0] TRINAL_MASK = 8'hF0;  // act, dea, sai, uoa

  // ****************************************
  // reset values and status codes
  // ****************************************
  localparam logic [7:0] M_TX_RST     = 8'hFF;
  localparam logic [3:0] CODE_ACTIVE  = 4'hB;
  localparam logic [3:0] CODE_NO_TRSP = 4'hA;
  localparam logic [3:0] CODE_NO_SYNC = 4'h8;
  localparam logic [3:0] CODE_ERROR   = 4'h4;
  localparam logic [1:0] DEA_SF_COUNT = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_KHZ     = 100000;
  localparam int unsigned SF_LOSS_MS  = 480;
  localparam int unsigned SF_LOSS_CYC = SF_LOSS_MS * CLK_KHZ;

  typedef enum logic {DEA_IDLE, DEA_SEND} dea_state_t;

  // per-bit update value for M4 and M5/M6 subchannels
  function automatic logic [7:0] upd_val(input logic [1:0] mode, input logic [7:0] mask,
                                         input logic [7:0] cur, input logic [7:0] h1,
                                         input logic [7:0] h2, input logic [7:0] rg);
    logic [7:0] v;
    v = rg;
    for (int i = 0; i < 8; i++) begin
      if (mode == 2'h3) begin
        v[i] = cur[i];
      end else if (mask[i]) begin
        v[i] = (cur[i] == h1[i] && h1[i] == h2[i]) ? cur[i] : rg[i];
      end else if (mode == 2'h2) begin
        v[i] = cur[i];
      end else begin
        v[i] = (cur[i] == h1[i]) ? cur[i] : rg[i];
      end
    end
    return v;
  endfunction : upd_val

  // whether a subchannel register takes its new value this superframe
  function automatic logic upd_evt(input logic [1:0] mode, input logic [7:0] cur,
                                   input logic [7:0] h1, input logic [7:0] v,
                                   input logic [7:0] rg);
    return (mode == 2'h3) || (mode == 2'h2 && cur != h1) || (v != rg);
  endfunction : upd_evt

endpackage : maint_pkg

// [design/u_line_maintenance_channel.sv]
// maintenance channel control: M4/M5/M6/eoc receive registers, febe/nebe,
// deactivation sequencing and customer data gating
// assumes framer strobes (superframe ends, eoc ends, basic frame 2, tdm frame)
// arrive as one-cycle pulses on clk; nt_mode is a pin
`timescale 1ns/1ps
module u_line_maintenance_channel #(
  parameter int unsigned LOSS_CYCLES = maint_pkg::SF_LOSS_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic        nt_mode,
  input  wire logic        sf_sync,
  input  wire logic        linkup,
  input  wire logic        transparent,
  input  wire logic        line_deact,
  input  wire logic        rx_sf_end,
  input  wire logic [7:0]  rx_m4,
  input  wire logic [7:0]  rx_m56,
  input  wire logic        rx_febe,
  input  wire logic        rx_crc_err,
  input  wire logic        rx_eoc_end,
  input  wire logic [11:0] rx_eoc,
  input  wire logic        tx_sf_end,
  input  wire logic        tx_bf2_end,
  input  wire logic        tdm_frame,
  output logic      [7:0]  tx_m4,
  output logic      [7:0]  tx_m56,
  output logic             tx_febe,
  output logic             deact_out,
  output logic             warm_start,
  output logic             customer_pass,
  output logic             irq
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [2:0]            act_ctrl;
    logic [3:0]            irq_mask;
    logic [7:0]            m4_tx;
    logic [7:0]            m56_tx;
    logic [7:0]            m4_rx;
    logic [7:0]            m4_h1;
    logic [7:0]            m4_h2;
    logic [7:0]            m56_rx;
    logic [7:0]            m56_h1;
    logic [7:0]            m56_h2;
    logic [11:0]           eoc_rx;
    logic [11:0]           eoc_h1;
    logic [11:0]           eoc_h2;
    logic [7:0]            maint_ctrl;
    logic                  trinal;
    logic [3:0]            irq_st;
    logic                  febe_st;
    logic                  nebe_last;
    logic                  err_ind;
    logic [3:0]            code;
    logic [25:0]           loss_tmr;
    maint_pkg::dea_state_t st;
    logic [1:0]            dea_cnt;
    logic [7:0]            tx_m4;
    logic [7:0]            tx_m56;
    logic                  tx_febe;
    logic                  deact_out;
    logic                  warm_start;
    logic                  cust_pass;
    logic                  irq;
    logic [7:0]            rdata;
  } state_t;

  state_t     q;
  state_t     next_q;
  logic [1:0] rst_sync;
  logic       rst_n_i;
  logic [1:0] nt_sync;
  logic       nt;

  // reset release through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_i = rst_sync[1];

  // mode pin is asynchronous to clk
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nt_sync <= 2'h0;
    end else begin
      nt_sync <= {nt_sync[0], nt_mode};
    end
  end
  assign nt = nt_sync[1];

  // ****************************************
  // derived terms
  // ****************************************
  logic [1:0]  m4_mode;
  logic [1:0]  eoc_mode;
  logic [7:0]  m4_v;
  logic [7:0]  m56_v;
  logic        m4_upd;
  logic        m56_upd;
  logic        eoc_upd;
  logic        v_act;
  logic        v_dea;
  logic        auto_dea;
  logic [3:0]  code_now;
  logic        loss_to;

  assign m4_mode  = q.maint_ctrl[5:4];
  assign eoc_mode = q.maint_ctrl[7:6];
  // trinal check only covers the act/dea/sai/uoa positions
  assign m4_v     = maint_pkg::upd_val(m4_mode, q.trinal ? maint_pkg::TRINAL_MASK : 8'h00,
                                       rx_m4, q.m4_h1, q.m4_h2, q.m4_rx);
  assign m4_upd   = rx_sf_end && maint_pkg::upd_evt(m4_mode, rx_m4, q.m4_h1, m4_v, q.m4_rx);
  // M5/M6 share the M4 modes as one pair, no verification
  assign m56_v    = maint_pkg::upd_val(m4_mode, q.trinal ? maint_pkg::TRINAL_MASK : 8'h00,
                                       rx_m56, q.m56_h1, q.m56_h2, q.m56_rx);
  assign m56_upd  = rx_sf_end && maint_pkg::upd_evt(m4_mode, rx_m56, q.m56_h1, m56_v, q.m56_rx);
  // eoc: every frame, trinal on new value, or new value
  always_comb begin
    unique case (eoc_mode)
      2'h3:    eoc_upd = rx_eoc_end;
      2'h2:    eoc_upd = rx_eoc_end && rx_eoc == q.eoc_h1 && q.eoc_h1 == q.eoc_h2
                         && rx_eoc != q.eoc_rx;
      default: eoc_upd = rx_eoc_end && rx_eoc != q.eoc_rx;
    endcase
  end
  // verification exists only in mode 0,0; dea verified in NT only
  assign v_act    = (m4_mode == 2'h0) && q.m4_rx[maint_pkg::ACT_BIT];
  assign v_dea    = (m4_mode == 2'h0) && nt && q.m4_rx[maint_pkg::DEA_BIT];
  assign auto_dea = nt && (m4_mode == 2'h0) && sf_sync && !q.m4_rx[maint_pkg::DEA_BIT];
  assign loss_to  = linkup && !sf_sync && (q.loss_tmr == 26'(LOSS_CYCLES - 1));

  // status code; lost transparency carries no timer
  always_comb begin
    if (q.err_ind) begin
      code_now = maint_pkg::CODE_ERROR;
    end else if (linkup && !sf_sync) begin
      code_now = maint_pkg::CODE_NO_SYNC;
    end else if (linkup && !transparent) begin
      code_now = maint_pkg::CODE_NO_TRSP;
    end else if (linkup) begin
      code_now = maint_pkg::CODE_ACTIVE;
    end else begin
      code_now = 4'h0;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [3:0] irq_set;
    logic [3:0] irq_clr;
    irq_set           = 4'h0;
    irq_clr           = 4'h0;
    next_q            = q;
    next_q.deact_out  = 1'b0;
    next_q.rdata      = 8'h00;
    // register writes
    if (wr) begin
      unique case (addr)
        maint_pkg::ACT_CONTROL_IDX: next_q.act_ctrl   = wdata[2:0];
        maint_pkg::IRQ_MASK_IDX:    next_q.irq_mask   = wdata[3:0];
        maint_pkg::M4_TX_IDX:       next_q.m4_tx      = wdata;
        maint_pkg::M56_IDX:         next_q.m56_tx     = wdata;  // host febe input in bit 4
        maint_pkg::MAINT_CTRL_IDX:  next_q.maint_ctrl = wdata;
        maint_pkg::OVERLAY_IDX:     next_q.trinal     = wdata[0];
        maint_pkg::IRQ_STATUS_IDX:  irq_clr           = wdata[3:0];
        default: ;
      endcase
    end
    // automatic request set wins over a same-cycle write
    if (auto_dea) begin
      next_q.act_ctrl[maint_pkg::DEACT_BIT] = 1'b1;
    end
    // receive subchannel histories and registers
    if (rx_sf_end) begin
      next_q.m4_h1  = rx_m4;
      next_q.m4_h2  = q.m4_h1;
      next_q.m56_h1 = rx_m56;
      next_q.m56_h2 = q.m56_h1;
      // received febe only while synchronised and linked
      if (sf_sync && linkup) begin
        next_q.febe_st = rx_febe;
      end
      next_q.nebe_last = !rx_crc_err;
    end
    if (m4_upd) begin
      next_q.m4_rx = m4_v;
      irq_set[maint_pkg::IRQ_M4] = 1'b1;
    end
    if (m56_upd) begin
      next_q.m56_rx = m56_v;
      irq_set[maint_pkg::IRQ_M56] = 1'b1;
    end
    if (rx_eoc_end) begin
      next_q.eoc_h1 = rx_eoc;
      next_q.eoc_h2 = q.eoc_h1;
    end
    if (eoc_upd) begin
      next_q.eoc_rx = rx_eoc;
      irq_set[maint_pkg::IRQ_EOC] = 1'b1;
    end
    // lost superframe sync timer
    if (linkup && !sf_sync && !loss_to) begin
      next_q.loss_tmr = q.loss_tmr + 26'h1;
    end else begin
      next_q.loss_tmr = 26'h0;
    end
    if (loss_to) begin
      next_q.err_ind   = 1'b1;
      next_q.deact_out = !nt;  // NT waits for the line to drop
    end else if (sf_sync && linkup) begin
      next_q.err_ind = 1'b0;
    end
    // NT end: warm or cold start depends on the request bit
    if (nt && line_deact) begin
      next_q.warm_start = q.act_ctrl[maint_pkg::DEACT_BIT];
      if (!q.act_ctrl[maint_pkg::DEACT_BIT]) begin
        next_q.err_ind = 1'b1;
      end
      next_q.act_ctrl[maint_pkg::DEACT_BIT] = 1'b0;
    end
    // status code changes interrupt
    next_q.code = code_now;
    if (code_now != q.code) begin
      irq_set[maint_pkg::IRQ_STAT] = 1'b1;
    end
    // transmit framer load at superframe boundary, unless updates disabled
    if (tx_sf_end && !q.act_ctrl[maint_pkg::UPD_DIS_BIT]) begin
      next_q.tx_m4  = q.m4_tx;
      next_q.tx_m56 = q.m56_tx;
    end
    // febe out at end of basic frame 2, active low
    if (tx_bf2_end) begin
      next_q.tx_febe = q.maint_ctrl[maint_pkg::FEBE_CTL_BIT] ? q.m56_tx[maint_pkg::FEBE_BIT]
                       : (q.nebe_last & q.m56_tx[maint_pkg::FEBE_BIT]);
    end
    // LT deactivation sequence
    unique case (q.st)
      maint_pkg::DEA_IDLE: begin
        next_q.dea_cnt = 2'h0;
        if (!nt && q.act_ctrl[maint_pkg::DEACT_BIT] && !q.act_ctrl[maint_pkg::UPD_DIS_BIT]) begin
          next_q.st = maint_pkg::DEA_SEND;
        end
      end
      maint_pkg::DEA_SEND: begin
        // an NT end abandons the sequence before any pulse can leave
        if (nt) begin
          next_q.st = maint_pkg::DEA_IDLE;
        end else if (tx_sf_end && !q.tx_m4[maint_pkg::DEA_BIT]) begin
          // only superframes that really carried dea=0 are counted
          if (q.dea_cnt == maint_pkg::DEA_SF_COUNT - 2'h1) begin
            next_q.deact_out = 1'b1;
            next_q.st        = maint_pkg::DEA_IDLE;
            next_q.act_ctrl[maint_pkg::DEACT_BIT] = 1'b0;
          end else begin
            next_q.dea_cnt = q.dea_cnt + 2'h1;
          end
        end
      end
    endcase
    // customer data gate moves only on tdm frame boundary
    if (tdm_frame) begin
      next_q.cust_pass = v_act | q.act_ctrl[maint_pkg::CUST_EN_BIT];
    end
    // sticky flags: a set beats a clear in the same cycle
    next_q.irq_st = (q.irq_st & ~irq_clr) | irq_set;
    next_q.irq    = |(next_q.irq_st & q.irq_mask);
    // reads answer in the following cycle
    if (rd) begin
      unique case (addr)
        maint_pkg::ACT_STATUS_IDX:  next_q.rdata = {4'h0, q.code};
        maint_pkg::ACT_CONTROL_IDX: next_q.rdata = {5'h00, q.act_ctrl};
        maint_pkg::IRQ_MASK_IDX:    next_q.rdata = {4'h0, q.irq_mask};
        maint_pkg::M4_TX_IDX:       next_q.rdata = q.m4_tx;
        maint_pkg::M4_RX_IDX:       next_q.rdata = q.m4_rx;
        maint_pkg::M56_IDX:         next_q.rdata = q.m56_rx;
        maint_pkg::VERIFIED_IDX:    next_q.rdata = {3'h0, q.febe_st, q.nebe_last,
                                                    v_act, v_dea, 1'b0};
        maint_pkg::MAINT_CTRL_IDX:  next_q.rdata = q.maint_ctrl;
        maint_pkg::OVERLAY_IDX:     next_q.rdata = {7'h00, q.trinal};
        maint_pkg::EOC_IDX:         next_q.rdata = q.eoc_rx[11:4];
        maint_pkg::IRQ_STATUS_IDX:  next_q.rdata = {q.eoc_rx[3:0], q.irq_st};
        default:                    next_q.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q          <= '0;
      q.m4_tx    <= maint_pkg::M_TX_RST;
      q.m56_tx   <= maint_pkg::M_TX_RST;  // reserved bits idle high
      q.tx_m4    <= maint_pkg::M_TX_RST;
      q.tx_m56   <= maint_pkg::M_TX_RST;
      q.tx_febe  <= 1'b1;
      q.st       <= maint_pkg::DEA_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign rdata         = q.rdata;
  assign tx_m4         = q.tx_m4;
  assign tx_m56        = q.tx_m56;
  assign tx_febe       = q.tx_febe;
  assign deact_out     = q.deact_out;
  assign warm_start    = q.warm_start;
  assign customer_pass = q.cust_pass;
  assign irq           = q.irq;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_i);

  three_sf_a: assert property (q.st == maint_pkg::DEA_SEND && tx_sf_end && !nt
    && !q.tx_m4[maint_pkg::DEA_BIT] && q.dea_cnt == 2'h2 |=> deact_out && q.st == maint_pkg::DEA_IDLE)
    else $error("deactivation not issued after third dea superframe");
  nt_no_deact_a: assert property (deact_out |-> !$past(nt))
    else $error("NT end started deactivation");
  warm_start_a: assert property (nt && line_deact && q.act_ctrl[maint_pkg::DEACT_BIT]
    |=> warm_start && !q.act_ctrl[maint_pkg::DEACT_BIT])
    else $error("requested NT deactivation not warm");
  cold_start_a: assert property (nt && line_deact && !q.act_ctrl[maint_pkg::DEACT_BIT]
    && !auto_dea |=> !warm_start ##1 q.code == maint_pkg::CODE_ERROR)
    else $error("unrequested NT deactivation not cold with error");
  febe_auto_a: assert property (tx_bf2_end && !q.maint_ctrl[maint_pkg::FEBE_CTL_BIT]
    |=> tx_febe == ($past(q.nebe_last) & $past(q.m56_tx[maint_pkg::FEBE_BIT])))
    else $error("automatic febe wrong");
  febe_hold_a: assert property (rx_sf_end && !(sf_sync && linkup) |=> $stable(q.febe_st))
    else $error("received febe updated without sync");
  nebe_crc_a: assert property (rx_sf_end && rx_crc_err |=> !q.nebe_last)
    else $error("nebe not cleared by crc error");
  eoc_every_a: assert property (rx_eoc_end && eoc_mode == 2'h3
    |=> q.eoc_rx == $past(rx_eoc) && q.irq_st[maint_pkg::IRQ_EOC])
    else $error("eoc not updated every frame");
  m4_every_a: assert property (rx_sf_end && m4_mode == 2'h3 |=> q.m4_rx == $past(rx_m4)
    ##1 (irq || !q.irq_mask[maint_pkg::IRQ_M4] || !q.irq_st[maint_pkg::IRQ_M4]))
    else $error("M4 not updated every superframe");
  cust_gate_a: assert property (tdm_frame && q.act_ctrl[maint_pkg::CUST_EN_BIT]
    |=> customer_pass)
    else $error("customer enable not applied at tdm frame");
  cust_wait_a: assert property (!tdm_frame |=> $stable(customer_pass))
    else $error("customer gate moved off tdm frame");

  cov_lt_deact: cover property (q.st == maint_pkg::DEA_SEND ##[1:1000] deact_out);
  cov_warm:     cover property (nt && line_deact && q.act_ctrl[maint_pkg::DEACT_BIT]);
  cov_cold:     cover property (nt && line_deact && !q.act_ctrl[maint_pkg::DEACT_BIT]);
  cov_trinal:   cover property (eoc_mode == 2'h2 && eoc_upd);

endmodule : u_line_maintenance_channel

// [dv/far_end_line.sv]
// far-end line and framer model: superframe strobes, received bits
// assumes one clock shared with the block; a superframe lasts SF_LEN cycles
`timescale 1ns/1ps
module far_end_line #(
  parameter int SF_LEN = 40
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  m4_val,
  input  wire logic        crc_val,
  output logic             rx_sf_end,
  output logic             tx_sf_end,
  output logic             tx_bf2_end,
  output logic             tdm_frame,
  output logic             rx_eoc_end,
  output logic      [7:0]  rx_m4,
  output logic      [7:0]  rx_m56,
  output logic             rx_febe,
  output logic             rx_crc_err,
  output logic      [11:0] rx_eoc
);
  int cnt;

  // ************************************
  // superframe position
  // ************************************
  // free running, so strobes keep their spacing across tests
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
    end else begin
      cnt <= (cnt == SF_LEN - 1) ? 0 : cnt + 1;
    end
  end

  // strobes; off-strobe data toggles so a stale byte is never valid
  always_comb begin
    rx_sf_end  = (cnt == 0);
    tx_sf_end  = (cnt == 0);
    tx_bf2_end = (cnt == 10);
    tdm_frame  = (cnt % 20 == 7);
    rx_eoc_end = (cnt % 20 == 0);
    rx_m4      = rx_sf_end ? m4_val : ~m4_val ^ cnt[7:0];
    rx_m56     = rx_sf_end ? ~m4_val : cnt[7:0];  // distinct from M4 byte
    rx_febe    = rx_sf_end ? 1'b1 : cnt[0];
    rx_crc_err = rx_sf_end ? crc_val : ~crc_val;
    rx_eoc     = {cnt[3:0], cnt[7:0]};
  end
endmodule : far_end_line

// [dv/testbench.sv]
// self-checking bench: register accesses against the far-end line model
// assumes the block's register indices from the package, LT mode first, then NT
`timescale 1ns/1ps
module testbench;
  logic        clk, rstn, wr, rd, nt_mode, crc_val;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, m4_val, d, tx_m4, tx_m56;
  logic        sf_sync, linkup, line_deact, warm_start;
  logic        rx_sf_end, tx_sf_end, tx_bf2_end, tdm_frame, rx_eoc_end;
  logic        rx_febe, rx_crc_err, tx_febe, deact_out, customer_pass, irq;
  logic [7:0]  rx_m4, rx_m56;
  logic [11:0] rx_eoc;
  int          n_fail, check_count, n;
  localparam int LOSS = 50;  // shortened sync loss limit for simulation

  far_end_line far_u (.clk(clk), .rstn(rstn), .m4_val(m4_val), .crc_val(crc_val),
    .rx_sf_end(rx_sf_end), .tx_sf_end(tx_sf_end), .tx_bf2_end(tx_bf2_end),
    .tdm_frame(tdm_frame), .rx_eoc_end(rx_eoc_end), .rx_m4(rx_m4), .rx_m56(rx_m56),
    .rx_febe(rx_febe), .rx_crc_err(rx_crc_err), .rx_eoc(rx_eoc));

  u_line_maintenance_channel #(.LOSS_CYCLES(LOSS)) dut_u (.clk(clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .nt_mode(nt_mode),
    .sf_sync(sf_sync), .linkup(linkup), .transparent(1'b1), .line_deact(line_deact),
    .rx_sf_end(rx_sf_end), .rx_m4(rx_m4), .rx_m56(rx_m56), .rx_febe(rx_febe),
    .rx_crc_err(rx_crc_err), .rx_eoc_end(rx_eoc_end), .rx_eoc(rx_eoc),
    .tx_sf_end(tx_sf_end), .tx_bf2_end(tx_bf2_end), .tdm_frame(tdm_frame),
    .tx_m4(tx_m4), .tx_m56(tx_m56), .tx_febe(tx_febe), .deact_out(deact_out),
    .warm_start(warm_start), .customer_pass(customer_pass), .irq(irq));

  // ************************************
  // bus and check tasks
  // ************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  // ends one cycle after a received superframe strobe
  task automatic wait_sf(input int k);
    repeat (k) begin
      @(negedge clk);
      while (!rx_sf_end) @(negedge clk);
      @(negedge clk);
    end
  endtask : wait_sf

  // ends two falling edges after the basic frame 2 strobe
  task automatic wait_bf2;
    while (!tx_bf2_end) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask : wait_bf2

  // far line terminal drops the line: sync and linkup go with it
  task automatic drop_line;
    @(posedge clk);
    line_deact <= 1'b1;
    linkup     <= 1'b0;
    sf_sync    <= 1'b0;
    @(posedge clk);
    line_deact <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : drop_line

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
  end
  always #5 clk = ~clk;

  // watchdog: the tests need about 1000 cycles
  initial begin
    repeat (6000) @(posedge clk);
    n_fail++;
    $display("BAD watchdog expected done seen hang");
    wrap_up();
  end

  // ************************************
  // test sequence
  // ************************************
  initial begin
    rstn = 1'b0; addr = 4'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    nt_mode = 1'b0; m4_val = 8'hFF; crc_val = 1'b0;
    sf_sync = 1'b1;
    linkup = 1'b1;
    line_deact = 1'b0;
    n_fail = 0; check_count = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    chk("tx_febe reset", 8'h01, {7'h0, tx_febe});
    // customer enable waits for a tdm frame boundary
    wait_sf(1);
    wr_reg(maint_pkg::ACT_CONTROL_IDX, 8'h01);
    @(negedge clk);
    chk("pass before tdm", 8'h00, {7'h0, customer_pass});
    while (!tdm_frame) @(negedge clk);
    repeat (2) @(negedge clk);
    chk("pass after tdm", 8'h01, {7'h0, customer_pass});
    // M4 mode 1,1: every superframe updates and interrupts
    wr_reg(maint_pkg::ACT_CONTROL_IDX, 8'h00);
    wr_reg(maint_pkg::IRQ_MASK_IDX, 8'h02);
    wr_reg(maint_pkg::MAINT_CTRL_IDX, 8'h30);
    m4_val <= 8'hA5;
    wait_sf(1);
    rd_reg(maint_pkg::M4_RX_IDX, d);
    chk("m4 mode 11", 8'hA5, d);
    rd_reg(maint_pkg::M56_IDX, d);
    chk("m56 mode 11", 8'h5A, d);
    wr_reg(maint_pkg::IRQ_STATUS_IDX, 8'h0F);
    wait_sf(1);
    chk("m4 irq unchanged", 8'h01, {7'h0, irq});
    // M4 mode 0,0: needs two equal superframes
    wr_reg(maint_pkg::MAINT_CTRL_IDX, 8'h00);
    wr_reg(maint_pkg::IRQ_STATUS_IDX, 8'h0F);
    m4_val <= 8'h5A;
    wait_sf(1);
    rd_reg(maint_pkg::M4_RX_IDX, d);
    chk("m4 mode 00 first", 8'hA5, d);
    wait_sf(1);
    rd_reg(maint_pkg::M4_RX_IDX, d);
    chk("m4 mode 00 second", 8'h5A, d);
    // M4 mode 1,0: any changed bit updates at once
    wr_reg(maint_pkg::MAINT_CTRL_IDX, 8'h20);
    m4_val <= 8'h5B;
    wait_sf(1);
    rd_reg(maint_pkg::M4_RX_IDX, d);
    chk("m4 mode 10", 8'h5B, d);
    // line deactivation from this end, host order fixed by the device
    wait_sf(1);
    wr_reg(maint_pkg::ACT_CONTROL_IDX, 8'h02);
    wr_reg(maint_pkg::M4_TX_IDX, 8'hBF);
    wr_reg(maint_pkg::ACT_CONTROL_IDX, 8'h04);
    n = 0;
    for (int i = 0; i < 250 && deact_out !== 1'b1; i++) begin
      @(negedge clk);
      if (tx_sf_end) n++;
    end
    chk("deact boundaries", 8'h04, n[7:0]);
    chk("tx m4 dea", 8'hBF, tx_m4);
    // crc error: nebe active, outgoing febe low after basic frame 2
    crc_val <= 1'b1;
    wait_sf(1);
    wait_bf2();
    chk("febe forced", 8'h00, {7'h0, tx_febe});
    rd_reg(maint_pkg::VERIFIED_IDX, d);
    chk("febe nebe status", 8'h10, d & 8'h18);
    crc_val <= 1'b0;
    wait_sf(1);
    wait_bf2();
    chk("febe clear", 8'h01, {7'h0, tx_febe});
    // host-driven febe: a crc error no longer forces the outgoing bit
    wr_reg(maint_pkg::MAINT_CTRL_IDX, 8'h22);
    crc_val <= 1'b1;
    wait_sf(1);
    wait_bf2();
    chk("host febe high", 8'h01, {7'h0, tx_febe});
    wr_reg(maint_pkg::M56_IDX, 8'hEF);
    crc_val <= 1'b0;
    wait_bf2();
    chk("host febe low", 8'h00, {7'h0, tx_febe});
    chk("tx m56 load", 8'hEF, tx_m56);
    wr_reg(maint_pkg::M56_IDX, 8'hFF);
    // short loss of superframe sync: back to active, with interrupt
    wr_reg(maint_pkg::IRQ_MASK_IDX, 8'h08);
    sf_sync <= 1'b0;
    repeat (3) @(posedge clk);
    rd_reg(maint_pkg::ACT_STATUS_IDX, d);
    chk("lost sync code", 8'h08, d);
    wr_reg(maint_pkg::IRQ_STATUS_IDX, 8'h0F);
    sf_sync <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(maint_pkg::ACT_STATUS_IDX, d);
    chk("sync back code", 8'h0B, d);
    chk("sync back irq", 8'h01, {7'h0, irq});
    // long loss: the line terminal end gives up after the limit
    @(posedge clk);
    sf_sync <= 1'b0;
    @(negedge clk);
    n = 0;
    while (deact_out !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("loss limit cycles", 8'(LOSS), n[7:0]);
    rd_reg(maint_pkg::ACT_STATUS_IDX, d);
    chk("loss error code", 8'h04, d);
    @(posedge clk);
    sf_sync <= 1'b1;
    // NT end: received dea=0 under verification requests deactivation
    wr_reg(maint_pkg::MAINT_CTRL_IDX, 8'h00);
    nt_mode <= 1'b1;
    m4_val  <= 8'hBF;
    wait_sf(2);
    rd_reg(maint_pkg::ACT_CONTROL_IDX, d);
    chk("auto deact request", 8'h04, d);
    wait_bf2();
    while (!tdm_frame) @(negedge clk);
    repeat (2) @(negedge clk);
    chk("pass by act", 8'h01, {7'h0, customer_pass});
    drop_line();
    chk("warm start", 8'h01, {7'h0, warm_start});
    rd_reg(maint_pkg::ACT_STATUS_IDX, d);
    chk("warm code", 8'h00, d);
    @(posedge clk);
    sf_sync <= 1'b1;
    linkup  <= 1'b1;
    m4_val  <= 8'hFF;
    wait_sf(2);
    wr_reg(maint_pkg::ACT_CONTROL_IDX, 8'h00);
    drop_line();
    chk("cold start", 8'h00, {7'h0, warm_start});
    rd_reg(maint_pkg::ACT_STATUS_IDX, d);
    chk("cold error code", 8'h04, d);
    @(posedge clk);
    sf_sync <= 1'b1;
    linkup  <= 1'b1;
    // eoc every frame, then the trinal check holds the last message
    wr_reg(maint_pkg::MAINT_CTRL_IDX, 8'hC0);
    wait_sf(1);
    repeat (25) @(negedge clk);
    rd_reg(maint_pkg::EOC_IDX, d);
    chk("eoc every frame", 8'h41, d);
    wr_reg(maint_pkg::MAINT_CTRL_IDX, 8'h80);
    wait_sf(1);
    rd_reg(maint_pkg::EOC_IDX, d);
    chk("eoc trinal hold", 8'h41, d);
    wrap_up();
  end
endmodule : testbench
